// *** hdl/stpc_pkg.sv ***
// Shared constants for the standard timer pulse and capture block
package stpc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CMPA = 8'h08;
  localparam logic [7:0] OFS_CMPP = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  // Field positions
  localparam int RUN_BIT = 0;
  localparam int MODE_LO = 6;
  localparam int PIN_LO = 4;
  localparam int OC_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int DPX_BIT = 1;
  localparam int CCLR_BIT = 0;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  // Reset values and counter step
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [15:0] RST_CMPA = 16'h0000;
  localparam logic [7:0] RST_CMPP = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  // Operating modes
  typedef enum logic [1:0] {
    STPC_CMP = 2'h0,
    STPC_CAP = 2'h1,
    STPC_PWM = 2'h2,
    STPC_TMR = 2'h3
  } stpc_mode_e;
  // Pin function codes
  localparam logic [1:0] PIN_CAP_RISE = 2'h0;
  localparam logic [1:0] PIN_CAP_FALL = 2'h1;
  localparam logic [1:0] PIN_CAP_BOTH = 2'h2;
  localparam logic [1:0] PIN_CAP_OFF = 2'h3;
  localparam logic [1:0] PIN_PWM_INACT = 2'h0;
  localparam logic [1:0] PIN_PWM_ACT = 2'h1;
  localparam logic [1:0] PIN_PWM_OUT = 2'h2;
  localparam logic [1:0] PIN_SINGLE = 2'h3;
  localparam logic [1:0] PIN_CMP_LOW = 2'h1;
  localparam logic [1:0] PIN_CMP_HIGH = 2'h2;
  localparam logic [1:0] PIN_CMP_TOGGLE = 2'h3;
endpackage

// *** hdl/stpc_edge.sv ***
// Edge detector for a pin that is already synchronous to the clock
`timescale 1ns/100ps
module stpc_edge (
  input wire logic clk,     // Timer clock
  input wire logic rst_n,   // Asynchronous reset, active low
  input wire logic pin,     // Sampled pin level
  output logic rise,        // One-cycle pulse on low to high
  output logic fall         // One-cycle pulse on high to low
);
  logic prev_r;

  // Previous level; resets low so a pin high at reset counts as a rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin;
    end
  end

  // Edge pulses
  assign rise = pin && !prev_r;
  assign fall = !pin && prev_r;
endmodule

// *** hdl/stpc_timer.sv ***
// Standard timer: single pulse, capture and PWM modes behind AHB-Lite
// Notes on behaviour
// - PWM: each counter clear bounds one period
// - PWM generation runs under forced pin codes
// - PWM ignores the clear source select
// - Pulse starts by software or external edge
// - Run rise starts counter and pulse together
// - Run clear or A match ends pulse
// - Single pulse A match raises interrupt
// - Counter zeroed only on run rise
// - Single pulse ignores P, clear, swap
// - Capture counter starts on run rise
// - Active edge copies counter to A, interrupts
// - Capture counter free runs until run falls
// - Capture P match clears counter
// - Capture P match raises interrupt
// - Pin code 11 blocks capture only
// - P value zero gives full count
// - Capture mode has no output function
// - P compares upper byte, 256-clock steps
// - Sixteen-bit counter wraps after FFFF
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module stpc_timer (
  input wire logic hclk,               // Bus and timer clock
  input wire logic hresetn,            // Asynchronous reset, active low
  input wire logic hsel,               // Slave select
  input wire logic [31:0] haddr,       // Byte address
  input wire logic [1:0] htrans,       // Transfer type
  input wire logic hwrite,             // Write when high
  input wire logic [2:0] hsize,        // Word transfers only
  input wire logic [31:0] hwdata,      // Write data
  input wire logic hready,             // Bus ready
  output logic hreadyout,              // Always ready
  output logic hresp,                  // Always OKAY
  output logic [31:0] hrdata,          // Read data
  input wire logic ext_clock_pin,      // External trigger pin
  input wire logic capture_input_pin,  // Capture input pin
  output logic timer_out,              // Timer output pin
  output logic timer_irq               // Timer interrupt request
);
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic run_r;
  logic [7:0] ctrl1_r;
  logic [15:0] cmpa_r;
  logic [7:0] cmpp_r;
  logic [15:0] cnt_r;
  logic flag_a_r;
  logic flag_p_r;
  logic cmp_raw_r;
  logic out_r;
  logic irq_r;
  logic [31:0] hrdata_r;
  wire ext_rise;
  wire cap_rise;
  wire cap_fall;

  // Offset match, shared by write and read decoding
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  stpc_edge u_ext (
    .clk(hclk),
    .rst_n(hresetn),
    .pin(ext_clock_pin),
    .rise(ext_rise),
    .fall()
  );

  stpc_edge u_cap (
    .clk(hclk),
    .rst_n(hresetn),
    .pin(capture_input_pin),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  // Address phase capture; zero wait states so no stall logic
  wire addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      waddr_r <= addr_ok ? haddr[7:0] : waddr_r;
    end
  end

  // Write decode in the data phase
  wire wr_ctrl0 = wr_pend_r && hit(waddr_r, stpc_pkg::OFS_CTRL0);
  wire wr_ctrl1 = wr_pend_r && hit(waddr_r, stpc_pkg::OFS_CTRL1);
  wire wr_cmpa = wr_pend_r && hit(waddr_r, stpc_pkg::OFS_CMPA);
  wire wr_cmpp = wr_pend_r && hit(waddr_r, stpc_pkg::OFS_CMPP);
  wire wr_flags = wr_pend_r && hit(waddr_r, stpc_pkg::OFS_FLAGS);

  // Mode decode
  wire [1:0] mode = ctrl1_r[stpc_pkg::MODE_LO +: 2];
  wire [1:0] pinfn = ctrl1_r[stpc_pkg::PIN_LO +: 2];
  wire oc = ctrl1_r[stpc_pkg::OC_BIT];
  wire pol = ctrl1_r[stpc_pkg::POL_BIT];
  wire dpx = ctrl1_r[stpc_pkg::DPX_BIT];
  wire cclr = ctrl1_r[stpc_pkg::CCLR_BIT];
  wire is_cap = mode == stpc_pkg::STPC_CAP;
  wire is_pw = mode == stpc_pkg::STPC_PWM;
  wire is_sp = is_pw && pinfn == stpc_pkg::PIN_SINGLE;
  wire is_pwm = is_pw && !is_sp;
  wire is_cmp = mode == stpc_pkg::STPC_CMP || mode == stpc_pkg::STPC_TMR;
  wire act = oc ^ pol;  // Active pin level

  // Comparators; P looks at the upper byte only, so zero means FFFF
  wire [15:0] p_end = {cmpp_r, 8'h00} - stpc_pkg::CNT_STEP;
  wire p_hit = run_r && cnt_r == p_end;
  wire a_hit = run_r && cnt_r == cmpa_r;
  wire a_per = run_r && cnt_r == cmpa_r - stpc_pkg::CNT_STEP;

  // PWM runs for pin codes 00 to 10, code 11 gives single pulse; swap picks period source
  wire pwm_wrap = dpx ? a_per : p_hit;
  wire pwm_duty_p = cmpp_r == 8'h00 || cnt_r[15:8] < cmpp_r;
  wire pwm_lvl = dpx ? pwm_duty_p : cnt_r < cmpa_r;

  // Capture edge select; code 11 blocks capture only
  wire cap_edge = (pinfn == stpc_pkg::PIN_CAP_RISE && cap_rise)
               || (pinfn == stpc_pkg::PIN_CAP_FALL && cap_fall)
               || (pinfn == stpc_pkg::PIN_CAP_BOTH && (cap_rise || cap_fall));
  wire cap_ev = is_cap && cap_edge;

  // Run bit: hardware set beats hardware clear beats software
  wire run_nxt = (is_sp && ext_rise) ? 1'b1
               : (is_sp && a_hit) ? 1'b0
               : wr_ctrl0 ? hwdata[stpc_pkg::RUN_BIT] : run_r;
  wire run_start = run_nxt && !run_r;

  // Clear source; cclr only matters in compare modes
  wire cnt_clr = is_cap ? p_hit : is_pwm ? pwm_wrap : is_sp ? 1'b0
               : (cclr ? a_hit : p_hit);
  wire cnt_hold = !run_r || (is_sp && a_hit);

  // Counter zeroes as run rises or on the clear source, wraps after FFFF
  wire [15:0] cnt_nxt = run_start ? stpc_pkg::RST_COUNT
                      : cnt_hold ? cnt_r
                      : cnt_clr ? stpc_pkg::RST_COUNT : cnt_r + stpc_pkg::CNT_STEP;

  // Capture overwrites a software write in the same cycle
  wire [15:0] cmpa_nxt = cap_ev ? cnt_r : wr_cmpa ? hwdata[15:0] : cmpa_r;
  wire [7:0] ctrl1_nxt = wr_ctrl1 ? hwdata[7:0] : ctrl1_r;
  wire [7:0] cmpp_nxt = wr_cmpp ? hwdata[7:0] : cmpp_r;

  // Flag events; A flag skipped for a zero A value in compare modes
  wire set_a = cap_ev || (!is_cap && a_hit && !(is_cmp && cmpa_r == 16'h0000));
  wire set_p = p_hit && !is_sp && !(is_cmp && cclr);
  wire clr_a = wr_flags && hwdata[stpc_pkg::FLAG_A_BIT];
  wire clr_p = wr_flags && hwdata[stpc_pkg::FLAG_P_BIT];
  wire flag_a_nxt = set_a || (flag_a_r && !clr_a);  // Set wins over clear
  wire flag_p_nxt = set_p || (flag_p_r && !clr_p);

  // Compare mode pin action on an A match; reloads on run rise
  wire cmp_raw_nxt = run_start ? oc
                   : !(is_cmp && a_hit) ? cmp_raw_r
                   : pinfn == stpc_pkg::PIN_CMP_LOW ? 1'b0
                   : pinfn == stpc_pkg::PIN_CMP_HIGH ? 1'b1
                   : pinfn == stpc_pkg::PIN_CMP_TOGGLE ? !cmp_raw_r : cmp_raw_r;

  // Pin level per mode; capture and timer modes leave it low
  wire pwm_pin = pinfn == stpc_pkg::PIN_PWM_INACT ? !act
               : pinfn == stpc_pkg::PIN_PWM_ACT ? act
               : pwm_lvl ? act : !act;
  wire out_nxt = is_sp ? (run_nxt ? act : !act)
               : is_pwm ? pwm_pin
               : mode == stpc_pkg::STPC_CMP ? cmp_raw_nxt ^ pol : 1'b0;

  // Read mux from next values so a read right after a write sees it
  wire [7:0] raddr = haddr[7:0];
  wire [31:0] rd_nxt =
      hit(raddr, stpc_pkg::OFS_CTRL0) ? {31'h0000_0000, run_nxt}
    : hit(raddr, stpc_pkg::OFS_CTRL1) ? {24'h00_0000, ctrl1_nxt}
    : hit(raddr, stpc_pkg::OFS_CMPA) ? {16'h0000, cmpa_nxt}
    : hit(raddr, stpc_pkg::OFS_CMPP) ? {24'h00_0000, cmpp_nxt}
    : hit(raddr, stpc_pkg::OFS_COUNT) ? {16'h0000, cnt_nxt}
    : hit(raddr, stpc_pkg::OFS_FLAGS) ? {30'h0000_0000, flag_p_nxt, flag_a_nxt}
    : 32'h0000_0000;

  // Timer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
      ctrl1_r <= stpc_pkg::RST_CTRL1;
      cmpa_r <= stpc_pkg::RST_CMPA;
      cmpp_r <= stpc_pkg::RST_CMPP;
      cnt_r <= stpc_pkg::RST_COUNT;
      cmp_raw_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      ctrl1_r <= ctrl1_nxt;
      cmpa_r <= cmpa_nxt;
      cmpp_r <= cmpp_nxt;
      cnt_r <= cnt_nxt;
      cmp_raw_r <= cmp_raw_nxt;
    end
  end

  // Flags and registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
      out_r <= 1'b0;
      irq_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      flag_a_r <= flag_a_nxt;
      flag_p_r <= flag_p_nxt;
      out_r <= out_nxt;
      irq_r <= flag_a_nxt || flag_p_nxt;
      hrdata_r <= (addr_ok && !hwrite) ? rd_nxt : hrdata_r;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign timer_out = out_r;
  assign timer_irq = irq_r;

  // Checks on the timer behaviour
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sp_pulse_end_a: assert property (is_sp && a_hit && !ext_rise
      |=> !run_r && timer_out == !$past(act))
    else $error("single pulse did not end on A match");
  sp_lead_a: assert property ($rose(run_r) && is_sp
      |-> timer_out == act && cnt_r == 16'h0000)
    else $error("pulse leading edge or counter start wrong");
  sp_ext_trig_a: assert property (is_sp && ext_rise |=> run_r)
    else $error("external edge did not set run");
  sp_stop_a: assert property (is_sp && !run_r && !ext_rise && !wr_ctrl0
      |=> $stable(cnt_r))
    else $error("stopped counter moved");
  sp_irq_a: assert property (is_sp && a_hit ##1 !clr_a |-> ##1 timer_irq)
    else $error("A match raised no request");
  cap_latch_a: assert property (cap_ev |=> cmpa_r == $past(cnt_r) && flag_a_r)
    else $error("capture did not latch counter");
  cap_off_a: assert property (is_cap && pinfn == stpc_pkg::PIN_CAP_OFF && !wr_cmpa
      |=> $stable(cmpa_r))
    else $error("capture with capture disabled");
  cap_wrap_a: assert property (is_cap && p_hit && !wr_ctrl0
      |=> cnt_r == 16'h0000 && flag_p_r)
    else $error("P match did not clear counter");
  cap_run_a: assert property (is_cap && run_r && !p_hit
      |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("capture counter not free running");
  pwm_wrap_a: assert property (is_pwm && !dpx && p_hit |=> cnt_r == 16'h0000)
    else $error("PWM period clear missing");
  irq_flags_a: assert property (timer_irq == (flag_a_r || flag_p_r))
    else $error("request disagrees with flags");

  // Capture: pin stays quiet, P match wraps and asks for service
  cap_quiet_a: assert property (is_cap |=> !timer_out)
    else $error("capture mode drove the pin");
  cap_p_irq_a: assert property (is_cap && p_hit |=> timer_irq && flag_p_r)
    else $error("P match raised no request");
  cap_start_a: assert property (is_cap && $rose(run_r) |-> cnt_r == 16'h0000)
    else $error("capture counter did not start from zero");
  p_period_a: assert property (is_cap && run_r && cnt_r[7:0] == 8'hFF
      && cnt_r[15:8] == 8'(cmpp_r - 8'h01) |=> cnt_r == 16'h0000)
    else $error("P period not a whole number of 256 counts");
  wrap_full_a: assert property (!is_sp && run_r && cnt_r == 16'hFFFF
      |=> cnt_r == 16'h0000)
    else $error("counter did not wrap after full count");

  // Single pulse: software end, idle level, P and trigger gating
  sp_sw_end_a: assert property (is_sp && run_r && wr_ctrl0 && !hwdata[stpc_pkg::RUN_BIT]
      && !ext_rise |=> !run_r && timer_out == !$past(act))
    else $error("software clear did not end the pulse");
  sp_idle_a: assert property (is_sp && !run_r && !ext_rise && !wr_ctrl0
      |=> timer_out == !$past(act))
    else $error("idle pulse pin not at inactive level");
  sp_p_ignored_a: assert property (is_sp && !flag_p_r |=> !flag_p_r)
    else $error("P match flagged in single pulse mode");
  ext_refused_a: assert property (!is_sp && ext_rise && !wr_ctrl0
      |=> run_r == $past(run_r))
    else $error("trigger pin acted outside single pulse mode");

  // PWM: forced codes and clear select leave the period running
  pwm_forced_a: assert property (is_pwm && pinfn == stpc_pkg::PIN_PWM_ACT
      |=> timer_out == $past(act))
    else $error("forced active level missing");
  pwm_count_a: assert property (is_pwm && run_r && !dpx && !p_hit
      |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("PWM counter stalled");
  pwm_cclr_a: assert property (is_pwm && !dpx && cclr && a_hit && !p_hit
      |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("clear select acted in PWM mode");

  // Flags: a clear with no fresh event drops the flag
  flag_clear_a: assert property (clr_a && !set_a |=> !flag_a_r)
    else $error("A flag survived its clear");

  sp_pulse_c: cover property (is_sp && $rose(run_r) ##[1:1000] $fell(run_r));
  cap_event_c: cover property (cap_ev ##[1:1000] cap_ev);
  cap_wrap_c: cover property (is_cap && p_hit);
  pwm_wrap_c: cover property (is_pwm && pwm_wrap);
  sp_trig_c: cover property (is_sp && ext_rise);
endmodule

// *** sim/stpc_pins.sv ***
// Far-side pin model: external trigger and capture input
`timescale 1ns/100ps
module stpc_pins (
  input wire logic hclk,          // Timer clock
  output logic ext_clock_pin,     // Trigger pin
  output logic capture_input_pin  // Capture pin
);
  // Both pins are driven levels that start low; the capture pin holds each new level
  initial begin
    ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end
  // Trigger pulse; only its rising edge may start a pulse
  task automatic trig(input int w);
    @(posedge hclk) ext_clock_pin <= 1'b1;
    repeat (w) @(posedge hclk);
    ext_clock_pin <= 1'b0;
  endtask
  // New capture level, changed just after an edge
  task automatic cap(input logic lvl);
    @(posedge hclk) capture_input_pin <= lvl;
  endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the standard timer block
`timescale 1ns/100ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic timer_out;
  logic timer_irq;
  logic ext_clock_pin;
  logic capture_input_pin;
  logic [31:0] rd;
  logic [31:0] exp_a;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 89;
  int cyc = 0;
  int c0, n, w, act, hit;

  // Clock, and a cycle count that drives the counter model
  always #4 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  stpc_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin), .timer_out(timer_out), .timer_irq(timer_irq));
  stpc_pins u_pins (.hclk(hclk), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin));

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Counter model: zero at run rise, wraps after per counts
  function automatic int model_cnt(input int per);
    return (cyc - c0) % per;
  endfunction
  // Later value within a few counts of the earlier one; hides bus latency
  function automatic int close(input int a, input int b, input int per);
    return (((a - b) % per + per) % per) <= 3;
  endfunction

  // Single AHB transfer; no latency assumed, hready decides
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask
  task automatic nearcnt(input int per);
    bus(1'b0, stpc_pkg::OFS_COUNT, 32'h0000_0000);
    check(32'(close(model_cnt(per), rd, per)), 32'h0000_0001);
  endtask
  // Timer stopped, flags cleared, then set up
  task automatic cfg(input logic [31:0] c1, input int a, input int p);
    bus(1'b1, stpc_pkg::OFS_CTRL0, 32'h0000_0000);
    bus(1'b1, stpc_pkg::OFS_FLAGS, 32'h0000_0003);
    bus(1'b1, stpc_pkg::OFS_CTRL1, c1);
    bus(1'b1, stpc_pkg::OFS_CMPA, 32'(a));
    bus(1'b1, stpc_pkg::OFS_CMPP, 32'(p));
  endtask
  task automatic run;
    bus(1'b1, stpc_pkg::OFS_CTRL0, 32'h0000_0001);
    c0 = cyc;
  endtask
  task automatic wait_out(input logic lvl, input int lim);
    w = 0;
    while (timer_out !== lvl && w < lim) begin
      @(posedge hclk);
      #1;
      w++;
    end
  endtask

  // Hang guard, sized well above the long wrap test
  initial begin
    repeat (90000) @(posedge hclk);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values; the unmapped offset reads zero and drops writes
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    for (int i = 0; i <= 24; i += 4) rdchk(8'(i), 32'h0000_0000);
    check({31'h0, hresp}, 32'h0000_0000);
    // Software pulses in every polarity; widths straddle a P match
    for (int k = 0; k < 4; k++) begin
      act = (k & 1) ^ (k >> 1);
      n = 240 + k * 20 + ($unsigned($random(seed)) % 16);
      cfg(32'h0000_00B0 | 32'(k << 2) | ($unsigned($random(seed)) % 4), n, 1);
      check({31'h0, timer_out}, 32'(1 - act));
      run();
      check({31'h0, timer_out}, 32'(act));
      wait_out(~act[0], 400);
      check(32'(w), 32'(n + 1));
      check({31'h0, timer_irq}, 32'h0000_0001);
      rdchk(stpc_pkg::OFS_COUNT, 32'(n));
      rdchk(stpc_pkg::OFS_CTRL0, 32'h0000_0000);
      rdchk(stpc_pkg::OFS_FLAGS, 32'h0000_0001);
    end
    // Software stop in mid pulse: no match flag, pin inactive
    cfg(32'h0000_00B8, 1000, 1);
    run();
    repeat (20) @(posedge hclk);
    bus(1'b1, stpc_pkg::OFS_CTRL0, 32'h0000_0000);
    rdchk(stpc_pkg::OFS_FLAGS, 32'h0000_0000);
    check({31'h0, timer_out}, 32'h0000_0000);
    // Pulse started by the trigger pin
    cfg(32'h0000_00B8, 50, 1);
    u_pins.trig(2);
    wait_out(1'b1, 8);
    check({31'h0, timer_out}, 32'h0000_0001);
    rdchk(stpc_pkg::OFS_CTRL0, 32'h0000_0001);
    wait_out(1'b0, 80);
    rdchk(stpc_pkg::OFS_FLAGS, 32'h0000_0001);
    // Capture for every edge code; code 11 blocks capture only
    for (int k = 0; k < 4; k++) begin
      cfg(32'h0000_004C | 32'(k << 4) | ($unsigned($random(seed)) % 4), 16'hFFFF, 1);
      run();
      exp_a = 32'h0000_FFFF;
      hit = 0;
      for (int e = 1; e >= 0; e--) begin
        repeat ($unsigned($random(seed)) % 64) @(posedge hclk);
        u_pins.cap(e[0]);
        #1;
        n = model_cnt(256);
        repeat (3) @(posedge hclk);
        bus(1'b0, stpc_pkg::OFS_CMPA, 32'h0000_0000);
        if (k == 2 || k == (e ^ 1)) begin
          check(rd, 32'(n));
          exp_a = rd;
          hit = 1;
        end else begin
          check(rd, exp_a);
        end
      end
      check({31'h0, timer_out}, 32'h0000_0000);
      repeat (300) @(posedge hclk);
      nearcnt(256);
      rdchk(stpc_pkg::OFS_FLAGS, 32'(hit + 2));
    end
    // Zero P value runs the full range, then wraps
    cfg(32'h0000_0070, 0, 0);
    run();
    repeat (300) @(posedge hclk);
    nearcnt(65536);
    repeat (65300) @(posedge hclk);
    nearcnt(65536);
    // Run fall freezes the count; trigger pin ignored outside single pulse
    bus(1'b1, stpc_pkg::OFS_CTRL0, 32'h0000_0000);
    u_pins.trig(2);
    bus(1'b0, stpc_pkg::OFS_COUNT, 32'h0000_0000);
    n = rd;
    repeat (10) @(posedge hclk);
    rdchk(stpc_pkg::OFS_COUNT, 32'(n));
    rdchk(stpc_pkg::OFS_CTRL0, 32'h0000_0000);
    // PWM duty 64 of 256, the same for either clear source select
    for (int k = 0; k < 2; k++) begin
      cfg(32'h0000_00A8 | 32'(k), 64, 1);
      run();
      repeat (8) @(posedge hclk);
      hit = 0;
      repeat (512) begin
        @(posedge hclk);
        #1;
        hit += timer_out;
      end
      check(32'(hit), 32'h0000_0080);
    end
    // Forced pin levels; the period keeps running behind them
    for (int k = 0; k < 2; k++) begin
      cfg(32'h0000_0088 | 32'(k << 4), 64, 1);
      run();
      repeat (300) @(posedge hclk);
      #1;
      check({31'h0, timer_out}, 32'(k));
      rdchk(stpc_pkg::OFS_FLAGS, 32'h0000_0003);
    end
    print_verdict();
  end
endmodule
